// ---- fsl_pkg.sv ----
// Purpose: shared constants and field layouts of the fan-speed loop block
// Assumes: 125 MHz system clock, 254 kHz nominal loop oscillator
// Notes:   register reset values are used by the core only; the bench also uses the selects
package fsl_pkg;

  localparam int unsigned CLK_FREQ_HZ = 125_000_000;
  localparam int unsigned OSC_FREQ_HZ = 254_000;
  // internal oscillator tick, rounded down to whole system cycles
  localparam int unsigned OSC_DIV_CYC = CLK_FREQ_HZ / OSC_FREQ_HZ;
  localparam int unsigned OSC_DIV_W   = 9;
  localparam int unsigned BASE_DIV    = 128;
  localparam int unsigned BASE_DIV_W  = 7;
  // base ticks per count-time step
  localparam int unsigned CT_UNIT_TICKS = 64;
  localparam int unsigned CT_W          = 16;

  localparam int unsigned NUM_PINS   = 5;
  localparam int unsigned NUM_ALARMS = 5;

  localparam logic [2:0] SEL_CFG    = 3'h0;
  localparam logic [2:0] SEL_PINDEF = 3'h1;
  localparam logic [2:0] SEL_SPEED  = 3'h2;
  localparam logic [2:0] SEL_DRIVE  = 3'h3;
  localparam logic [2:0] SEL_CTIME  = 3'h4;
  localparam logic [2:0] SEL_AEN    = 3'h5;

  localparam logic [7:0] CFG_RST    = 8'h00;
  localparam logic [7:0] PINDEF_RST = 8'hFF;
  localparam logic [7:0] SPEED_RST  = 8'hFF;
  localparam logic [7:0] DRIVE_RST  = 8'h00;
  localparam logic [7:0] CTIME_RST  = 8'h03;
  localparam logic [7:0] AEN_RST    = 8'h00;

  localparam logic [1:0] MODE_FULL_ON = 2'h0;
  localparam logic [1:0] MODE_OFF     = 2'h1;
  localparam logic [1:0] MODE_CLOSED  = 2'h2;
  localparam logic [1:0] MODE_OPEN    = 2'h3;

  localparam logic [1:0] PD_SPECIAL = 2'h1;
  localparam logic [1:0] PD_LOW     = 2'h2;
  localparam logic [1:0] PD_HIGH    = 2'h3;

  localparam logic [7:0] DRV_FULL = 8'h00;
  localparam logic [7:0] DRV_NONE = 8'hFF;
  localparam logic [2:0] PRESC_MAX_CODE = 3'h4;

  localparam int unsigned AL_MIN = 0;
  localparam int unsigned AL_MAX = 1;
  localparam int unsigned AL_OVF = 2;
  localparam int unsigned AL_P1  = 3;
  localparam int unsigned AL_P2  = 4;

  typedef struct packed {
    logic [1:0] spare;
    logic [1:0] mode;
    logic       fan_12v;
    logic [2:0] presc;
  } fsl_cfg_t;

  typedef struct packed {
    logic       p4;
    logic       p3;
    logic [1:0] p2;
    logic [1:0] p1;
    logic [1:0] p0;
  } fsl_pindef_t;

endpackage : fsl_pkg

// ---- fsl_tick_div.sv ----
// Purpose: divides a tick stream by a programmable count plus one
// Assumes: i_tick is a one-cycle pulse
// Notes:   a new divisor takes effect at once; one below the count wraps at the next tick
`timescale 1ns/1ns
module fsl_tick_div #(
  parameter int unsigned W = 8
) (
  // clock and reset
  input  wire logic         i_sys_clk,
  input  wire logic         i_resetn,
  // tick stream
  input  wire logic         i_tick,
  input  wire logic [W-1:0] i_div_m1,
  output logic              o_tick
);

  logic [W-1:0] cnt_reg;

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt_reg <= '0;
      o_tick  <= 1'b0;
    end else begin
      o_tick <= 1'b0;
      if (i_tick) begin
        if (cnt_reg >= i_div_m1) begin
          cnt_reg <= '0;
          o_tick  <= 1'b1;
        end else begin
          cnt_reg <= cnt_reg + 1'b1;
        end
      end
    end
  end

endmodule : fsl_tick_div

// ---- fsl_tach_count.sv ----
// Purpose: saturating tachometer pulse counter over a counting interval
// Assumes: i_pulse and i_end are one-cycle pulses
// Notes:   a pulse in the closing cycle starts the next interval
`timescale 1ns/1ns
module fsl_tach_count (
  // clock and reset
  input  wire logic       i_sys_clk,
  input  wire logic       i_resetn,
  // events
  input  wire logic       i_pulse,
  input  wire logic       i_end,
  // results
  output logic [7:0]      o_count,
  output logic            o_ovf
);

  logic [7:0] cnt_reg;

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt_reg <= 8'h00;
      o_count <= 8'h00;
      o_ovf   <= 1'b0;
    end else begin
      o_ovf <= i_pulse && (cnt_reg == 8'hFE);
      if (i_end) begin
        o_count <= cnt_reg;
        cnt_reg <= i_pulse ? 8'h01 : 8'h00;
      end else if (i_pulse && cnt_reg != 8'hFF) begin
        cnt_reg <= cnt_reg + 8'h01;
      end
    end
  end

  a_count_saturate : assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    cnt_reg == 8'hFF && !i_end |=> cnt_reg == 8'hFF)
    else $error("tach count wrapped past full");

endmodule : fsl_tach_count

// ---- fsl_fan_core.sv ----
// Purpose: fan-speed loop, tach monitor and general pin logic
// Assumes: host writes registers through a select/data strobe port
// Notes:   drive code low means high fan voltage
//
// Overview of operation
// - Loop clock divided by 128 gives the base tick.
// - Base tick divided by setpoint plus one gives the reference.
// - Closed loop raises drive voltage when prescaled tach rate is low.
// - Tach prescale divisor is one of 1, 2, 4, 8, 16.
// - Loop clock is the internal oscillator or an external clock.
// - Mode field value 10 at config bits 5:4 means closed loop.
// - Prescale code lives in config bits 2:0.
// - Speed setpoint is eight bits wide.
// - Eight-bit tach pulse count over a programmed interval is readable.
// - Tach count saturates at 255 instead of wrapping.
// - Count-time register sets the counting interval length.
// - Prescale never touches the reported tach count.
// - Tach overflow can raise an alarm when enabled.
// - Pins three and four: 0 drives low, 1 releases high.
// - Pins zero to two: 10 drives low, 11 releases high.
// - All pins come up released high.
// - Pin status shows the real level of every pin.
// - Pin zero code 01 makes it the active-low alert output.
// - Alert goes low when any enabled alarm is true.
// - Pin one code 01 makes it the full-on request input.
// - Full-on input held low forces maximum drive over any mode.
// - Modes: 00 full on, 01 off, 11 open loop.
// - Open loop drive follows the host drive register.
// - Alert holds until status read with cause gone, or disabled.
`timescale 1ns/1ns
module fsl_fan_core (
  // clock and reset
  input  wire logic                         i_sys_clk,
  input  wire logic                         i_resetn,
  // host register port
  input  wire logic                         i_reg_wr,
  input  wire logic [2:0]                   i_reg_sel,
  input  wire logic [7:0]                   i_reg_wdata,
  input  wire logic                         i_alarm_rd,
  // loop clock source
  input  wire logic                         i_loop_clk_sel,
  input  wire logic                         i_ext_loop_clk,
  // fan
  input  wire logic                         i_speed_sense,
  output logic [7:0]                        o_drive_code,
  // general pins, open drain
  input  wire logic [fsl_pkg::NUM_PINS-1:0] i_gp_in,
  output logic [fsl_pkg::NUM_PINS-1:0]      o_gp_out,
  output logic [fsl_pkg::NUM_PINS-1:0]      o_gp_oe,
  // readable state
  output logic [7:0]                        o_tach_count,
  output logic [fsl_pkg::NUM_PINS-1:0]      o_pin_status,
  output logic [fsl_pkg::NUM_ALARMS-1:0]    o_alarm_status
);

  fsl_pkg::fsl_cfg_t    cfg_reg;
  fsl_pkg::fsl_pindef_t pindef_reg;
  logic [7:0]           speed_reg;
  logic [7:0]           drive_reg;
  logic [7:0]           ctime_reg;
  logic [7:0]           aen_reg;

  // host writes
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cfg_reg    <= fsl_pkg::CFG_RST;
      pindef_reg <= fsl_pkg::PINDEF_RST;
      speed_reg  <= fsl_pkg::SPEED_RST;
      drive_reg  <= fsl_pkg::DRIVE_RST;
      ctime_reg  <= fsl_pkg::CTIME_RST;
      aen_reg    <= fsl_pkg::AEN_RST;
    end else if (i_reg_wr) begin
      unique case (i_reg_sel)
        fsl_pkg::SEL_CFG:    cfg_reg    <= i_reg_wdata;
        fsl_pkg::SEL_PINDEF: pindef_reg <= i_reg_wdata;
        fsl_pkg::SEL_SPEED:  speed_reg  <= i_reg_wdata;
        fsl_pkg::SEL_DRIVE:  drive_reg  <= i_reg_wdata;
        fsl_pkg::SEL_CTIME:  ctime_reg  <= i_reg_wdata;
        fsl_pkg::SEL_AEN:    aen_reg    <= i_reg_wdata;
        default: begin
        end
      endcase
    end
  end

  // loop clock: external input is taken as synchronous and edge detected
  logic ext_prev_reg;
  logic osc_tick;
  logic loop_tick;
  logic base_tick;
  logic ref_tick;

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ext_prev_reg <= 1'b0;
    end else begin
      ext_prev_reg <= i_ext_loop_clk;
    end
  end

  fsl_tick_div #(
    .W (fsl_pkg::OSC_DIV_W)
  ) u_osc_div (
    .i_sys_clk (i_sys_clk),
    .i_resetn  (i_resetn),
    .i_tick    (1'b1),
    .i_div_m1  (fsl_pkg::OSC_DIV_W'(fsl_pkg::OSC_DIV_CYC - 1)),
    .o_tick    (osc_tick)
  );

  // speed scales with whichever source is chosen
  assign loop_tick = i_loop_clk_sel ? (i_ext_loop_clk && !ext_prev_reg)
                                    : osc_tick;

  fsl_tick_div #(
    .W (fsl_pkg::BASE_DIV_W)
  ) u_base_div (
    .i_sys_clk (i_sys_clk),
    .i_resetn  (i_resetn),
    .i_tick    (loop_tick),
    .i_div_m1  (fsl_pkg::BASE_DIV_W'(fsl_pkg::BASE_DIV - 1)),
    .o_tick    (base_tick)
  );

  fsl_tick_div #(
    .W (8)
  ) u_ref_div (
    .i_sys_clk (i_sys_clk),
    .i_resetn  (i_resetn),
    .i_tick    (base_tick),
    .i_div_m1  (speed_reg),
    .o_tick    (ref_tick)
  );

  // tach edge detect
  logic sense_prev_reg;
  logic tach_pulse;

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      sense_prev_reg <= 1'b0;
    end else begin
      sense_prev_reg <= i_speed_sense;
    end
  end

  assign tach_pulse = i_speed_sense && !sense_prev_reg;

  // tach prescaler; codes above four fall back to divide by sixteen
  logic [3:0] presc_mask;
  logic [3:0] presc_cnt_reg;
  logic       scaled_pulse;

  always_comb begin
    if (cfg_reg.presc > fsl_pkg::PRESC_MAX_CODE) begin
      presc_mask = 4'hF;
    end else begin
      presc_mask = 4'((5'h01 << cfg_reg.presc) - 5'h01);
    end
  end

  assign scaled_pulse = tach_pulse && (presc_cnt_reg >= presc_mask);

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      presc_cnt_reg <= 4'h0;
    end else if (tach_pulse) begin
      presc_cnt_reg <= scaled_pulse ? 4'h0 : presc_cnt_reg + 4'h1;
    end
  end

  // prescaled pulses seen in the current reference period, saturating at two
  logic [1:0] fb_cnt_reg;

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      fb_cnt_reg <= 2'h0;
    end else if (ref_tick) begin
      fb_cnt_reg <= scaled_pulse ? 2'h1 : 2'h0;
    end else if (scaled_pulse && fb_cnt_reg != 2'h2) begin
      fb_cnt_reg <= fb_cnt_reg + 2'h1;
    end
  end

  // loop code: one step per period keeps the loop slow enough to settle
  logic [7:0] loop_code_reg;
  logic       closed_mode;

  assign closed_mode = cfg_reg.mode == fsl_pkg::MODE_CLOSED;

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      loop_code_reg <= fsl_pkg::DRV_FULL;
    end else if (closed_mode && ref_tick) begin
      if (fb_cnt_reg == 2'h0 && loop_code_reg != fsl_pkg::DRV_FULL) begin
        loop_code_reg <= loop_code_reg - 8'h01;
      end else if (fb_cnt_reg == 2'h2 && loop_code_reg != fsl_pkg::DRV_NONE) begin
        loop_code_reg <= loop_code_reg + 8'h01;
      end
    end
  end

  // drive selection; hardware full-on wins over everything
  logic       full_on_req;
  logic [7:0] drive_next;

  assign full_on_req = pindef_reg.p1 == fsl_pkg::PD_SPECIAL
                       && !i_gp_in[1];

  always_comb begin
    drive_next = fsl_pkg::DRV_FULL;
    if (full_on_req) begin
      drive_next = fsl_pkg::DRV_FULL;
    end else begin
      unique case (cfg_reg.mode)
        fsl_pkg::MODE_FULL_ON: drive_next = fsl_pkg::DRV_FULL;
        fsl_pkg::MODE_OFF:     drive_next = fsl_pkg::DRV_NONE;
        fsl_pkg::MODE_CLOSED:  drive_next = loop_code_reg;
        fsl_pkg::MODE_OPEN:    drive_next = drive_reg;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_drive_code <= fsl_pkg::DRV_FULL;
    end else begin
      o_drive_code <= drive_next;
    end
  end

  // counting interval in base ticks
  logic [fsl_pkg::CT_W-1:0] ct_cnt_reg;
  logic [fsl_pkg::CT_W-1:0] ct_limit;
  logic                     ct_end;
  logic                     tach_ovf;

  assign ct_limit = fsl_pkg::CT_W'((32'(ctime_reg) + 32'd1)
                    * fsl_pkg::CT_UNIT_TICKS - 32'd1);
  assign ct_end   = base_tick && (ct_cnt_reg >= ct_limit);

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ct_cnt_reg <= '0;
    end else if (ct_end) begin
      ct_cnt_reg <= '0;
    end else if (base_tick) begin
      ct_cnt_reg <= ct_cnt_reg + 1'b1;
    end
  end

  // raw pulses, never the prescaled ones
  fsl_tach_count u_tach (
    .i_sys_clk (i_sys_clk),
    .i_resetn  (i_resetn),
    .i_pulse   (tach_pulse),
    .i_end     (ct_end),
    .o_count   (o_tach_count),
    .o_ovf     (tach_ovf)
  );

  // alarms: sticky, a true cause beats the read clear
  logic [fsl_pkg::NUM_ALARMS-1:0] cause;
  logic                           alert_reg;

  always_comb begin
    cause                 = '0;
    cause[fsl_pkg::AL_MIN] = closed_mode && loop_code_reg == fsl_pkg::DRV_FULL;
    cause[fsl_pkg::AL_MAX] = closed_mode && loop_code_reg == fsl_pkg::DRV_NONE;
    cause[fsl_pkg::AL_OVF] = tach_ovf;
    cause[fsl_pkg::AL_P1]  = !i_gp_in[1];
    cause[fsl_pkg::AL_P2]  = !i_gp_in[2];
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_alarm_status <= '0;
    end else begin
      o_alarm_status <= (o_alarm_status & ~{fsl_pkg::NUM_ALARMS{i_alarm_rd}})
                        | (cause & aen_reg[fsl_pkg::NUM_ALARMS-1:0]);
    end
  end

  // disabling an alarm drops the alert at once
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      alert_reg <= 1'b0;
    end else begin
      alert_reg <= |(o_alarm_status & aen_reg[fsl_pkg::NUM_ALARMS-1:0]);
    end
  end

  // pin drivers; enable high pulls the pin low, data stays low
  logic [fsl_pkg::NUM_PINS-1:0] oe_next;
  logic [1:0]                   pd2 [0:2];

  assign pd2[0] = pindef_reg.p0;
  assign pd2[1] = pindef_reg.p1;
  assign pd2[2] = pindef_reg.p2;

  generate
    for (genvar g = 0; g < 3; g++) begin : g_pd2
      if (g == 0) begin : g_alert
        assign oe_next[g] = (pd2[g] == fsl_pkg::PD_LOW)
                            || (pd2[g] == fsl_pkg::PD_SPECIAL && alert_reg);
      end else begin : g_plain
        assign oe_next[g] = pd2[g] == fsl_pkg::PD_LOW;
      end
    end
  endgenerate

  assign oe_next[3] = !pindef_reg.p3;
  assign oe_next[4] = !pindef_reg.p4;

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_gp_oe  <= '0;
      o_gp_out <= '0;
    end else begin
      o_gp_oe  <= oe_next;
      o_gp_out <= '0;
    end
  end

  // real pin level, so an outside low is visible to the host
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_pin_status <= '1;
    end else begin
      o_pin_status <= i_gp_in;
    end
  end

  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_resetn);

  a_full_on_wins : assert property (
    full_on_req |=> o_drive_code == fsl_pkg::DRV_FULL)
    else $error("full-on input did not force full drive");

  a_mode_off_drive : assert property (
    cfg_reg.mode == fsl_pkg::MODE_OFF && !full_on_req |=> o_drive_code == fsl_pkg::DRV_NONE)
    else $error("full-off mode left drive on");

  a_open_loop_follow : assert property (
    cfg_reg.mode == fsl_pkg::MODE_OPEN && !full_on_req |=> o_drive_code == $past(drive_reg))
    else $error("open loop drive not following register");

  a_loop_slow_up : assert property (
    closed_mode && ref_tick && fb_cnt_reg == 2'h0 && loop_code_reg != fsl_pkg::DRV_FULL
    |=> loop_code_reg == $past(loop_code_reg) - 8'h01)
    else $error("slow fan did not get more voltage");

  a_loop_one_step : assert property (
    !ref_tick |=> $stable(loop_code_reg))
    else $error("loop code moved without a reference period");

  a_pin_low_code : assert property (
    !pindef_reg.p3 ##1 !pindef_reg.p3 |-> o_gp_oe[3])
    else $error("pin three not driven low");

  a_pin_high_code : assert property (
    pindef_reg.p2 == fsl_pkg::PD_HIGH |=> !o_gp_oe[2])
    else $error("pin two not released");

  a_alert_hold : assert property (
    |(o_alarm_status & aen_reg[fsl_pkg::NUM_ALARMS-1:0]) && !i_alarm_rd
    ##1 $stable(aen_reg) |=> alert_reg)
    else $error("alert released without read or disable");

  a_alert_pin : assert property (
    alert_reg && pindef_reg.p0 == fsl_pkg::PD_SPECIAL |=> o_gp_oe[0])
    else $error("alert not driven on pin zero");

  a_pin_level : assert property (
    ##1 o_pin_status == $past(i_gp_in))
    else $error("pin status not tracking pin level");

endmodule : fsl_fan_core

// ---- fsl_far_side.sv ----
// Purpose: fan tach source and open-drain pin wiring beside the fan core
// Assumes: tach pulses are periodic, period given in system cycles
// Notes:   pins have pull-ups, so a released pin reads high
`timescale 1ns/1ns
module fsl_far_side (
  // clock and reset
  input  wire logic        i_sys_clk,
  input  wire logic        i_resetn,
  // fan
  input  wire logic [15:0] i_tach_period,
  output logic             o_speed_sense,
  // pins
  input  wire logic [4:0]  i_gp_out,
  input  wire logic [4:0]  i_gp_oe,
  input  wire logic [4:0]  i_ext_low,
  output logic [4:0]       o_gp_level
);
  logic [15:0] cnt_reg;

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt_reg <= 16'h0000;
    end else if (cnt_reg + 16'h0001 >= i_tach_period) begin
      cnt_reg <= 16'h0000;
    end else begin
      cnt_reg <= cnt_reg + 16'h0001;
    end
  end

  // zero period is a stalled fan: sense rests low, no stray edges
  assign o_speed_sense = (i_tach_period != 16'h0000) && (cnt_reg < (i_tach_period >> 1));
  // pull-up wins unless some driver sinks the line
  assign o_gp_level = ~((i_gp_oe & ~i_gp_out) | i_ext_low);
endmodule : fsl_far_side

// ---- tb_top.sv ----
// Purpose: self-checking bench of the fan core
// Assumes: external loop clock toggles every cycle, so base tick is 256 cycles
// Notes:   count time 0 gives a 16384-cycle tach interval
`timescale 1ns/1ns
module tb_top;
  logic        i_sys_clk    = 1'b0;
  logic        i_resetn     = 1'b0;
  logic        reg_wr;
  logic [2:0]  reg_sel;
  logic [7:0]  reg_wdata;
  logic        alarm_rd;
  logic        ext_clk;
  logic        loop_sel;
  logic        speed_sense;
  logic [7:0]  drive;
  logic [4:0]  gp_in;
  logic [4:0]  gp_out;
  logic [4:0]  gp_oe;
  logic [4:0]  ext_low;
  logic [7:0]  tach;
  logic [4:0]  pin_status;
  logic [4:0]  alarm;
  logic [15:0] tach_period;
  logic [7:0]  d0;
  int          n;
  int          error_cnt;
  int          total_checks;
  logic [7:0]  pd [2]       = '{8'hAE, 8'h7B};
  logic [7:0]  oe_exp [2]   = '{8'h0D, 8'h12};
  logic [7:0]  mode_exp [4] = '{8'h00, 8'hFF, 8'h00, 8'h40};

  always #4 i_sys_clk = ~i_sys_clk;
  always @(posedge i_sys_clk) ext_clk <= ~ext_clk;

  fsl_fan_core u_dut (
    .i_sys_clk      (i_sys_clk),
    .i_resetn       (i_resetn),
    .i_reg_wr       (reg_wr),
    .i_reg_sel      (reg_sel),
    .i_reg_wdata    (reg_wdata),
    .i_alarm_rd     (alarm_rd),
    .i_loop_clk_sel (loop_sel),
    .i_ext_loop_clk (ext_clk),
    .i_speed_sense  (speed_sense),
    .o_drive_code   (drive),
    .i_gp_in        (gp_in),
    .o_gp_out       (gp_out),
    .o_gp_oe        (gp_oe),
    .o_tach_count   (tach),
    .o_pin_status   (pin_status),
    .o_alarm_status (alarm)
  );

  fsl_far_side u_far (
    .i_sys_clk     (i_sys_clk),
    .i_resetn      (i_resetn),
    .i_tach_period (tach_period),
    .o_speed_sense (speed_sense),
    .i_gp_out      (gp_out),
    .i_gp_oe       (gp_oe),
    .i_ext_low     (ext_low),
    .o_gp_level    (gp_in)
  );

  task automatic end_sim;
    if (error_cnt == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [2:0] sel, input logic [7:0] d);
    @(posedge i_sys_clk);
    reg_wr    <= 1'b1;
    reg_sel   <= sel;
    reg_wdata <= d;
    @(posedge i_sys_clk);
    reg_wr    <= 1'b0;
  endtask : wr

  task automatic cyc(input int k);
    repeat (k) @(negedge i_sys_clk);
  endtask : cyc

  // bounded: a stuck loop must not hang the run
  task automatic wait_chg(output int k);
    logic [7:0] p;
    p = drive;
    k = 0;
    while (drive === p && k < 2000) begin
      @(negedge i_sys_clk);
      k++;
    end
    if (k >= 2000) begin
      error_cnt++;
      $display("mismatch at %0t: drive code never moved", $time);
      end_sim();
    end
  endtask : wait_chg

  initial begin
    reg_wr = 1'b0;
    reg_sel = 3'h0;
    reg_wdata = 8'h00;
    alarm_rd = 1'b0;
    ext_clk = 1'b0;
    loop_sel = 1'b1;
    ext_low = 5'h00;
    tach_period = 16'h0000;
    error_cnt = 0;
    total_checks = 0;
    repeat (8) @(posedge i_sys_clk);
    i_resetn <= 1'b1;
    cyc(3);
    chk(drive, 8'h00);
    chk({3'h0, gp_oe}, 8'h00);
    chk({3'h0, pin_status}, 8'h1F);
    for (int i = 0; i < 2; i++) begin
      wr(fsl_pkg::SEL_PINDEF, pd[i]);
      cyc(3);
      chk({3'h0, gp_oe}, oe_exp[i]);
      chk({3'h0, gp_out}, 8'h00);
      chk({3'h0, pin_status}, {3'h0, ~oe_exp[i][4:0]});
    end
    wr(fsl_pkg::SEL_PINDEF, 8'hFF);
    @(posedge i_sys_clk) ext_low <= 5'h04;
    cyc(3);
    chk({3'h0, pin_status}, 8'h1B);
    @(posedge i_sys_clk) ext_low <= 5'h00;
    wr(fsl_pkg::SEL_DRIVE, 8'h40);
    for (int m = 0; m < 4; m++) begin
      if (m != 2) begin
        wr(fsl_pkg::SEL_CFG, {2'b00, 2'(m), 4'h0});
        cyc(3);
        chk(drive, mode_exp[m]);
      end
    end
    wr(fsl_pkg::SEL_PINDEF, 8'hF7);
    wr(fsl_pkg::SEL_CFG, 8'h10);
    @(posedge i_sys_clk) ext_low <= 5'h02;
    cyc(3);
    chk(drive, 8'h00);
    @(posedge i_sys_clk) ext_low <= 5'h00;
    cyc(3);
    chk(drive, 8'hFF);
    // pass through open loop, then close the loop; loop code is still 00 from reset
    wr(fsl_pkg::SEL_CFG, 8'h30);
    wr(fsl_pkg::SEL_SPEED, 8'h00);
    wr(fsl_pkg::SEL_CTIME, 8'h00);
    wr(fsl_pkg::SEL_CFG, 8'h24);
    @(posedge i_sys_clk) tach_period <= 16'd128;
    cyc(32868);
    chk(tach, 8'd128);
    chk(drive, 8'h00);
    wr(fsl_pkg::SEL_SPEED, 8'h03);
    wr(fsl_pkg::SEL_PINDEF, 8'hFD);
    wr(fsl_pkg::SEL_AEN, 8'h04);
    wr(fsl_pkg::SEL_CFG, 8'h20);
    @(posedge i_sys_clk) tach_period <= 16'd32;
    cyc(1);
    wait_chg(n);
    d0 = drive;
    wait_chg(n);
    chk(8'(n - 960), 8'd64);
    chk(drive, d0 + 8'h01);
    cyc(32868);
    chk(tach, 8'hFF);
    chk({7'h0, alarm[2]}, 8'h01);
    chk({7'h0, gp_oe[0]}, 8'h01);
    @(posedge i_sys_clk) tach_period <= 16'h0000;
    cyc(10);
    chk({7'h0, gp_oe[0]}, 8'h01);
    @(posedge i_sys_clk) alarm_rd <= 1'b1;
    @(posedge i_sys_clk) alarm_rd <= 1'b0;
    cyc(4);
    chk({7'h0, alarm[2]}, 8'h00);
    chk({7'h0, gp_oe[0]}, 8'h00);
    // stalled fan: the first step may still see old pulses, the second must lower the code
    wait_chg(n);
    d0 = drive;
    wait_chg(n);
    chk(drive, d0 - 8'h01);
    // internal source: a base tick takes far longer than this window
    @(posedge i_sys_clk) loop_sel <= 1'b0;
    wr(fsl_pkg::SEL_SPEED, 8'h00);
    n = 0;
    d0 = drive;
    repeat (2000) begin
      @(negedge i_sys_clk);
      if (drive !== d0) begin
        n++;
      end
      d0 = drive;
    end
    chk(8'(n > 1), 8'h00);
    end_sim();
  end
endmodule : tb_top
